// ==== common/driver_global_config_params.svh ====
// Purpose: constants for the driver global configuration register
// Assumes: 16-bit register reached by a register address on the control interface
// Notes:   all writable fields reset to zero
// Function
// - per-output underload masks hide that output's underload
// - all-output mask hides every underload from the global bit
// - thermal mask suppresses the global thermal warning
// - discharge enable turns on mirror PWM discharge
// - discharge active disables mirror overcurrent recovery
// - select clear: 7-bit duty from shared registers
// - select set while the internal generator is in use: 10-bit duty, own register each
// - 10-bit duty is field plus one over 1024
`ifndef DRIVER_GLOBAL_CONFIG_PARAMS_SVH
`define DRIVER_GLOBAL_CONFIG_PARAMS_SVH
`define CFG_ADDR          6'h3F
`define CFG_RESET         16'h0000
`define CFG_WRITE_MASK    16'h40BA
`define CFG_MASK_NO_MIRROR 16'h403A
`define CFG_BIT_RES_SEL   14
`define CFG_BIT_DISCHARGE 7
`define CFG_BIT_HS1_MASK  5
`define CFG_BIT_LS1_MASK  4
`define CFG_BIT_TW_MASK   3
`define CFG_BIT_ALL_MASK  1
`endif

// ==== common/driver_global_config_pkg.sv ====
// Purpose: types for the driver global configuration register
// Assumes: nothing
// Notes:   resolution mode as an enum
package driver_global_config_pkg;
   typedef enum logic {
      RES_7BIT  = 1'b0,
      RES_10BIT = 1'b1
   } pwm_res_type;
   typedef struct packed {
      logic [15:0] cfg;
   } cfg_state_type;
endpackage

// ==== design/driver_global_config_register.sv ====
// Purpose: global configuration register and the gating it applies
// Assumes: write strobe, address and data are synchronous to clk_sys
// Notes:   discharge enable only has effect when hasMirror is set
`include "driver_global_config_params.svh"
`timescale 1ns/1ps
module driver_global_config_register
   import driver_global_config_pkg::*;
#(
   parameter bit HAS_MIRROR = 1'b1
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // register access
   input  wire logic        regWrite,
   input  wire logic [5:0]  regAddr,
   input  wire logic [15:0] regWdata,
   output logic      [15:0] regRdata,
   // fault sources
   input  wire logic        underloadHs1,
   input  wire logic        underloadLs1,
   input  wire logic        underloadOther,
   input  wire logic        thermalWarnRaw,
   // fault outputs
   output logic             underloadFailure,
   output logic             thermalWarningFlag,
   // mirror output
   input  wire logic        mirrorDischargeActive,
   input  wire logic        ocRecoveryCfg,
   output logic             mirrorDischargeEnable,
   output logic             ocRecoveryEnable,
   // pwm duty selection
   input  wire logic        internalPwmSelect,
   input  wire logic [9:0]  dutyOwn [4],
   input  wire logic [6:0]  dutyShared [2],
   output logic             pwmTenBit,
   output logic      [9:0]  dutyCode [4]
);

   ////////////////////////////////////////////////////////////////////////
   // state and decoded views

   cfg_state_type state_q;
   cfg_state_type state_d;
   pwm_res_type   resMode;
   logic [15:0]   cfg;
   logic [15:0]   writeMask;
   logic          cfgWriteHit;
   logic          allMaskSet;
   logic          hs1MaskSet;
   logic          ls1MaskSet;
   logic          twMaskSet;
   logic          dischargeBit;
   logic          hs1Visible;
   logic          ls1Visible;
   logic          anyUnderload;
   logic          dischargeRunning;
   logic          tenBitMode;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // address match for the configuration register
   function automatic logic isCfgAddr(input logic [5:0] addr);
      isCfgAddr = (addr == `CFG_ADDR);
   endfunction

   // writable bits of the fitted variant; without the mirror D7 is reserved
   function automatic logic [15:0] maskFor(input bit hasMirror);
      if (hasMirror) begin
         maskFor = `CFG_WRITE_MASK;
      end else begin
         maskFor = `CFG_MASK_NO_MIRROR;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register write path

   assign writeMask   = maskFor(HAS_MIRROR);
   assign cfgWriteHit = regWrite && isCfgAddr(regAddr);

   always_comb begin
      state_d = state_q;
      if (cfgWriteHit) begin
         // reserved positions are dropped here so they can never be stored
         state_d.cfg = regWdata & writeMask;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_q.cfg <= `CFG_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // field views

   assign cfg          = state_q.cfg;
   assign regRdata     = cfg;
   assign resMode      = pwm_res_type'(cfg[`CFG_BIT_RES_SEL]);
   assign allMaskSet   = cfg[`CFG_BIT_ALL_MASK];
   assign hs1MaskSet   = cfg[`CFG_BIT_HS1_MASK];
   assign ls1MaskSet   = cfg[`CFG_BIT_LS1_MASK];
   assign twMaskSet    = cfg[`CFG_BIT_TW_MASK];
   assign dischargeBit = cfg[`CFG_BIT_DISCHARGE];

   ////////////////////////////////////////////////////////////////////////
   // underload gating
   // kept combinational: a masked fault must not leak through for a cycle

   always_comb begin
      hs1Visible       = 1'b0;
      ls1Visible       = 1'b0;
      anyUnderload     = 1'b0;
      underloadFailure = 1'b0;
      if (underloadHs1 && !hs1MaskSet) begin
         hs1Visible = 1'b1;
      end
      if (underloadLs1 && !ls1MaskSet) begin
         ls1Visible = 1'b1;
      end
      anyUnderload = hs1Visible || ls1Visible || underloadOther;
      if (allMaskSet) begin
         // the global mask wins over every per-output report
         underloadFailure = 1'b0;
      end else begin
         underloadFailure = anyUnderload;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // thermal warning gating

   always_comb begin
      thermalWarningFlag = 1'b0;
      if (twMaskSet) begin
         thermalWarningFlag = 1'b0;
      end else begin
         thermalWarningFlag = thermalWarnRaw;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mirror discharge and recovery

   always_comb begin
      mirrorDischargeEnable = 1'b0;
      if (HAS_MIRROR) begin
         mirrorDischargeEnable = dischargeBit;
      end
   end

   assign dischargeRunning = mirrorDischargeEnable && mirrorDischargeActive;

   always_comb begin
      ocRecoveryEnable = ocRecoveryCfg;
      if (dischargeRunning) begin
         // discharge overrides the recovery setting outright
         ocRecoveryEnable = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // duty resolution
   // generator drives (code+1)/1024 in 10-bit, (code+1)/128 in 7-bit

   always_comb begin
      case (resMode)
         RES_10BIT: begin
            tenBitMode = 1'b1;
         end
         RES_7BIT: begin
            tenBitMode = 1'b0;
         end
         default: begin
            tenBitMode = 1'b0;
         end
      endcase
   end

   // own duty fields only count while the internal generator is in use
   assign pwmTenBit = tenBitMode && internalPwmSelect;

   ////////////////////////////////////////////////////////////////////////
   // per-lamp duty selection

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_duty
         logic [9:0] ownCode;
         logic [9:0] sharedCode;

         assign ownCode    = dutyOwn[i];
         // lamps pair up on one shared 7-bit register in 7-bit mode
         assign sharedCode = {3'h0, dutyShared[i / 2]};

         always_comb begin
            if (pwmTenBit) begin
               dutyCode[i] = ownCode;
            end else begin
               dutyCode[i] = sharedCode;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // limitation: the stored fields are only as fresh as the last accepted
   // write; a write to any other address leaves them untouched
   // trade-off: all gating is combinational, so fault inputs reach the
   // global flags in the same cycle at the cost of a longer input path

endmodule

// ==== test/driver_global_config_checker.sv ====
// Purpose: port assertions for the global config register
// Assumes: HAS_MIRROR set
// Notes: none
`timescale 1ns/1ps
module driver_global_config_checker (
   input wire logic        clk_sys, rst_b, regWrite, underloadHs1, underloadLs1, underloadOther,
   input wire logic        thermalWarnRaw, mirrorDischargeActive, ocRecoveryCfg, internalPwmSelect,
   input wire logic        underloadFailure, thermalWarningFlag, ocRecoveryEnable, pwmTenBit,
   input wire logic        mirrorDischargeEnable,
   input wire logic [5:0]  regAddr,
   input wire logic [15:0] regWdata, regRdata
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_wr; regWrite && regAddr == 6'h3F |=> regRdata == ($past(regWdata) & 16'h40BA);
   endproperty
   a_wr: assert property (p_wr) else $error("config write wrong");
   property p_hold; !(regWrite && regAddr == 6'h3F) |=> $stable(regRdata); endproperty
   a_hold: assert property (p_hold) else $error("config changed");
   property p_uld; underloadFailure == (!regRdata[1] && (underloadHs1 && !regRdata[5]
      || underloadLs1 && !regRdata[4] || underloadOther)); endproperty
   a_uld: assert property (p_uld) else $error("underload gating");
   property p_tw; thermalWarningFlag == (thermalWarnRaw && !regRdata[3]); endproperty
   a_tw: assert property (p_tw) else $error("thermal gating");
   property p_oc; ocRecoveryEnable == (ocRecoveryCfg && !(regRdata[7] && mirrorDischargeActive));
   endproperty
   a_oc: assert property (p_oc) else $error("recovery gating");
   property p_dis; mirrorDischargeEnable == regRdata[7]; endproperty
   a_dis: assert property (p_dis) else $error("discharge enable");
   property p_res; pwmTenBit == (regRdata[14] && internalPwmSelect); endproperty
   a_res: assert property (p_res) else $error("resolution");
   cover property (regWrite && regAddr == 6'h3F);
   cover property (underloadHs1 && regRdata[5]);
   cover property (mirrorDischargeActive && regRdata[7]);
endmodule
bind driver_global_config_register driver_global_config_checker checker_inst (.*);

// ==== test/host_model.sv ====
// Purpose: host writing the config register
// Assumes: one write per call
// Notes: strobe held one full cycle
`timescale 1ns/1ps
module host_model (
   input wire logic clk_sys,
   output logic regWrite,
   output logic [5:0] regAddr,
   output logic [15:0] regWdata
);
   initial begin
      regWrite = 0; regAddr = 0; regWdata = 0;
   end
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clk_sys); regWrite = 1; regAddr = a; regWdata = d;
      @(negedge clk_sys); regWrite = 0; regWdata = ~d;
   endtask
endmodule

// ==== test/tb_top.sv ====
// Purpose: random check of register and gating against a bench model
// Assumes: HAS_MIRROR set
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 0, rst_b = 0, regWrite, underloadFailure, thermalWarningFlag, pwmTenBit;
   logic underloadHs1, underloadLs1, underloadOther, thermalWarnRaw, mirrorDischargeActive;
   logic ocRecoveryCfg, internalPwmSelect, mirrorDischargeEnable, ocRecoveryEnable;
   logic [5:0] regAddr; logic [15:0] regWdata, regRdata, cfg = 0;
   logic [9:0] dutyOwn [4] = '{default: 0}, dutyCode [4]; logic [6:0] dutyShared [2] = '{0, 0};
   int mismatches = 0, check_count = 0;
   always #5 clk_sys = ~clk_sys;
   host_model host_model_inst (.*);
   driver_global_config_register driver_global_config_register_inst (.*);
   task chk(input string n, input logic [15:0] s, e);
      check_count++;
      if (s !== e) begin mismatches++; $display("Error %s exp %h seen %h", n, e, s); end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      {underloadHs1, underloadLs1, underloadOther, thermalWarnRaw} = 0;
      {mirrorDischargeActive, ocRecoveryCfg, internalPwmSelect} = 0;
      void'($urandom(85608));
      repeat (10) @(negedge clk_sys); rst_b = 1;
      chk("reset", regRdata, 0);
      for (int i = 0; i < 80; i++) begin
         logic [5:0] a; logic [15:0] d;
         a = (i % 3) ? 6'h3F : 6'($urandom); d = $urandom;
         host_model_inst.wr(a, d);
         if (a == 6'h3F) cfg = d & 16'h40BA;
         {underloadHs1, underloadLs1, underloadOther, thermalWarnRaw, mirrorDischargeActive,
            ocRecoveryCfg, internalPwmSelect} = 7'($urandom);
         foreach (dutyOwn[k]) dutyOwn[k] = 10'($urandom);
         foreach (dutyShared[k]) dutyShared[k] = 7'($urandom);
         #1;
         chk("rdata", regRdata, cfg);
         chk("uld", underloadFailure, !cfg[1] && (underloadHs1 && !cfg[5]
            || underloadLs1 && !cfg[4] || underloadOther));
         chk("tw", thermalWarningFlag, thermalWarnRaw && !cfg[3]);
         chk("dis", mirrorDischargeEnable, cfg[7]);
         chk("oc", ocRecoveryEnable, ocRecoveryCfg && !(cfg[7] && mirrorDischargeActive));
         foreach (dutyCode[k]) chk("duty", dutyCode[k], (cfg[14] && internalPwmSelect)
            ? dutyOwn[k] : {3'h0, dutyShared[k / 2]});
      end
      $display("random test done");
      @(negedge clk_sys); rst_b = 0;
      @(negedge clk_sys); rst_b = 1; cfg = 0; #1;
      chk("rerst", regRdata, cfg);
      host_model_inst.wr(6'h3F, 16'hFFFF); cfg = 16'h40BA; #1;
      chk("full", regRdata, cfg);
      $display("reset test done");
      finish_test;
   end
endmodule
